// [shared/framer_alarm_defs.vh]
// constants for the framer alarm action control block
// assumes a 40 MHz system clock and an 8-bit register file on a 32-bit wishbone word map
`ifndef FRAMER_ALARM_DEFS_VH
`define FRAMER_ALARM_DEFS_VH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define ADDR_REMOTE_ALARM_CTRL 8'h00
`define ADDR_EBIT_CTRL 8'h04
`define ADDR_AIS_LOOPBACK_CTRL 8'h08
`define ADDR_MULTIFRAME_TIMER_CFG 8'h0C
`define ADDR_TS16_LINE_CTRL 8'h10
`define ADDR_SYSTEM_SIGNALING_CTRL 8'h14
`define ADDR_DATA_LINK_CTRL 8'h18
`define ADDR_FORMAT_CTRL 8'h1C
`define ADDR_ACTION_STATUS 8'h20
`define REG_RESET 8'h00

// ----------------------------------------
// field positions
// ----------------------------------------
`define RA_LFA 0
`define RA_TS16 1
`define RA_TS0 2
`define RA_TIMER 3
`define RA_SA6_8 4
`define RA_SA6_C 5
`define RA_JPN_D4 6
`define RA_DEMAND 7
`define EB_CRC 3
`define EB_TS0 4
`define EB_TIMER 5
`define AIS_LFA 0
`define AIS_TIMER 1
`define AIS_DEMAND 3
`define AIS_LINE_LB 4
`define AIS_ESF_LINE_LB 6
`define AIS_ESF_PAY_LB 7
`define MFT_ENABLE 0
`define MFT_SHORT 2
`define MFT_LONG 3
`define MFT_BLOCK 7
`define T16_AUTO_RMA 4
`define T16_DEMAND_RMA 5
`define T16_LINE_AIS 6
`define SS_AUTO_AIS 6
`define SS_DEMAND_AIS 7
`define DL_SQUELCH 4

// ----------------------------------------
// frame formats (format register bits 2:0)
// ----------------------------------------
`define FMT_D4_US 3'h0
`define FMT_D4_JPN 3'h1
`define FMT_DDS 3'h2
`define FMT_ESF 3'h3
`define FMT_SLC96 3'h4
`define FMT_E1 3'h5

// ----------------------------------------
// codes and timing
// ----------------------------------------
`define SA6_CODE_8 4'h8
`define SA6_CODE_C 4'hC
`define ESF_YELLOW_PATTERN 16'hFF00
`define CLK_KHZ 40000
`define MF_SHORT_MS 100
`define MF_LONG_MS 400

`endif

// [core/framer_alarm_action_control.v]
// automatic and on-demand alarm action control for one framer channel
// assumes receive conditions and codes come from framer logic on clk_sys
//
// Operation
// - after reset every automatic alarm action is disabled until its enable is set
// - remote frame alarm while frame alignment is lost, when bit 0 set
// - remote frame alarm on ts16 multiframe loss, when bit 1 set
// - remote frame alarm on ts0 crc multiframe loss, when bit 2 set
// - configured 100/400 ms multiframe timer expiry drives alarm, e bit or system ais
// - remote frame alarm when received sa6 code equals 8, bit 4 set
// - remote frame alarm when received sa6 code equals C, bit 5 set
// - e bits sent zero on crc-4 error or ts0 multiframe loss when enabled
// - all-ones ais to system while frame alignment lost, when enabled
// - ts16 remote multiframe alarm to line on ts16 multiframe loss when enabled
// - ais into system time slot 16 on ts16 multiframe loss when enabled
// - t1 line loopback follows in-band loopback on/off codes when enabled
// - line loopback follows esf data link loopback on/off codes when enabled
// - payload loopback follows esf data link payload codes when enabled
// - japanese d4 remote alarm sets fs bit of frame 12 to one
// - us d4 remote alarm forces bit 2 of every time slot to zero
// - dds forces bit 6 of slot 24 zero; e1 drives a bit one
// - e1 ts16 remote multiframe alarm bit sent as one on demand
// - data link squelched to all ones in slc-96 or esf when enabled
//
// Chosen here: the register addresses and the Wishbone interface to the registers.
`timescale 1ns/1ps
`include "framer_alarm_defs.vh"

module framer_alarm_action_control #(
  parameter MF_SHORT_CYCLES = `MF_SHORT_MS * `CLK_KHZ,
  parameter MF_LONG_CYCLES = `MF_LONG_MS * `CLK_KHZ
) (
  input wire clk_sys,
  input wire rstn,
  input wire wbCycI,
  input wire wbStbI,
  input wire wbWeI,
  input wire [7:0] wbAdrI,
  input wire [3:0] wbSelI,
  input wire [31:0] wbDatI,
  output reg [31:0] wbDatO,
  output reg wbAckO,
  input wire frameAlignLost,
  input wire ts16MultiframeLost,
  input wire ts0MultiframeLost,
  input wire crc4Error,
  input wire [3:0] rxSa6Code,
  input wire lineLoopOnCode,
  input wire lineLoopOffCode,
  input wire esfLineLoopOnCode,
  input wire esfLineLoopOffCode,
  input wire esfPayloadLoopOnCode,
  input wire esfPayloadLoopOffCode,
  input wire dataLinkBitStrobe,
  output reg remoteFrameAlarm,
  output reg ebitZero,
  output reg systemAis,
  output reg ts16RemoteMfAlarm,
  output reg ts16SystemAis,
  output reg ts16LineAis,
  output reg fsFrame12One,
  output reg slotBit2Zero,
  output reg slot24Bit6Zero,
  output reg dataLinkOverride,
  output reg dataLinkBit,
  output reg lineLoopback,
  output reg payloadLoopback
);

  // ----------------------------------------
  // register file
  // ----------------------------------------
  reg [7:0] remoteAlarmCtrl_reg;
  reg [7:0] ebitCtrl_reg;
  reg [7:0] aisLoopbackCtrl_reg;
  reg [7:0] multiframeTimerCfg_reg;
  reg [7:0] ts16LineCtrl_reg;
  reg [7:0] systemSignalingCtrl_reg;
  reg [7:0] dataLinkCtrl_reg;
  reg [7:0] formatCtrl_reg;
  reg [7:0] readData_next;
  reg [7:0] statusByte;
  wire busReq;
  wire busWrite;
  wire [2:0] frameFormat;

  assign busReq = wbCycI & wbStbI & ~wbAckO;
  // only lane 0 carries data; writes without it are ignored
  assign busWrite = busReq & wbWeI & wbSelI[0];
  assign frameFormat = formatCtrl_reg[2:0];

  always @(posedge clk_sys) begin
    if (!rstn) begin
      remoteAlarmCtrl_reg <= `REG_RESET;
      ebitCtrl_reg <= `REG_RESET;
      aisLoopbackCtrl_reg <= `REG_RESET;
      multiframeTimerCfg_reg <= `REG_RESET;
      ts16LineCtrl_reg <= `REG_RESET;
      systemSignalingCtrl_reg <= `REG_RESET;
      dataLinkCtrl_reg <= `REG_RESET;
      formatCtrl_reg <= `REG_RESET;
    end else if (busWrite) begin
      case (wbAdrI)
        `ADDR_REMOTE_ALARM_CTRL: remoteAlarmCtrl_reg <= wbDatI[7:0];
        `ADDR_EBIT_CTRL: ebitCtrl_reg <= wbDatI[7:0];
        `ADDR_AIS_LOOPBACK_CTRL: aisLoopbackCtrl_reg <= wbDatI[7:0];
        `ADDR_MULTIFRAME_TIMER_CFG: multiframeTimerCfg_reg <= wbDatI[7:0];
        `ADDR_TS16_LINE_CTRL: ts16LineCtrl_reg <= wbDatI[7:0];
        `ADDR_SYSTEM_SIGNALING_CTRL: systemSignalingCtrl_reg <= wbDatI[7:0];
        `ADDR_DATA_LINK_CTRL: dataLinkCtrl_reg <= wbDatI[7:0];
        `ADDR_FORMAT_CTRL: formatCtrl_reg <= {5'h00, wbDatI[2:0]};
        default: formatCtrl_reg <= formatCtrl_reg;
      endcase
    end
  end

  // ----------------------------------------
  // multiframe loss timer
  // ----------------------------------------
  // counts while ts0 multiframe alignment stays lost, saturates at the long limit
  reg [23:0] mfCount_reg;
  wire [31:0] mfCountWide;
  wire shortExpired;
  wire longExpired;
  wire timerTrigger;

  assign mfCountWide = {8'h00, mfCount_reg};
  assign shortExpired = mfCountWide >= MF_SHORT_CYCLES;
  assign longExpired = mfCountWide >= MF_LONG_CYCLES;

  always @(posedge clk_sys) begin
    if (!rstn) begin
      mfCount_reg <= 24'h000000;
    end else if (!ts0MultiframeLost) begin
      mfCount_reg <= 24'h000000;
    end else if (!longExpired) begin
      mfCount_reg <= mfCount_reg + 24'h000001;
    end
  end

  // 0xxxx1x1 selects the short timer, 0xxx1xx1 the long one
  assign timerTrigger = ~multiframeTimerCfg_reg[`MFT_BLOCK] &
    multiframeTimerCfg_reg[`MFT_ENABLE] &
    ((multiframeTimerCfg_reg[`MFT_SHORT] & shortExpired) |
     (multiframeTimerCfg_reg[`MFT_LONG] & longExpired));

  // ----------------------------------------
  // automatic and on-demand alarm decisions
  // ----------------------------------------
  reg remoteAlarm_next;
  reg ebitZero_next;
  reg systemAis_next;
  reg ts16Rma_next;
  reg ts16SysAis_next;
  reg ts16LineAis_next;
  reg fs12_next;
  reg bit2Zero_next;
  reg bit6Zero_next;
  wire demandRemote;
  wire isE1;

  assign demandRemote = remoteAlarmCtrl_reg[`RA_DEMAND];
  assign isE1 = frameFormat == `FMT_E1;

  // everything is a plain level of trigger and enable, so it drops as soon as either goes
  always @* begin
    remoteAlarm_next =
      (remoteAlarmCtrl_reg[`RA_LFA] & frameAlignLost) |
      (remoteAlarmCtrl_reg[`RA_TS16] & ts16MultiframeLost) |
      (remoteAlarmCtrl_reg[`RA_TS0] & ts0MultiframeLost) |
      (remoteAlarmCtrl_reg[`RA_TIMER] & timerTrigger) |
      (remoteAlarmCtrl_reg[`RA_SA6_8] & (rxSa6Code == `SA6_CODE_8)) |
      (remoteAlarmCtrl_reg[`RA_SA6_C] & (rxSa6Code == `SA6_CODE_C)) |
      (demandRemote & isE1);
    ebitZero_next =
      (ebitCtrl_reg[`EB_CRC] & crc4Error) |
      (ebitCtrl_reg[`EB_TS0] & ts0MultiframeLost) |
      (ebitCtrl_reg[`EB_TIMER] & timerTrigger);
    systemAis_next =
      (aisLoopbackCtrl_reg[`AIS_LFA] & frameAlignLost) |
      (aisLoopbackCtrl_reg[`AIS_TIMER] & timerTrigger) |
      aisLoopbackCtrl_reg[`AIS_DEMAND];
    ts16Rma_next =
      (ts16LineCtrl_reg[`T16_AUTO_RMA] & ts16MultiframeLost) |
      (ts16LineCtrl_reg[`T16_DEMAND_RMA] & isE1);
    ts16SysAis_next =
      (systemSignalingCtrl_reg[`SS_AUTO_AIS] & ts16MultiframeLost) |
      systemSignalingCtrl_reg[`SS_DEMAND_AIS];
    ts16LineAis_next = ts16LineCtrl_reg[`T16_LINE_AIS];
    fs12_next = remoteAlarmCtrl_reg[`RA_JPN_D4] & (frameFormat == `FMT_D4_JPN);
    bit2Zero_next = demandRemote & (frameFormat == `FMT_D4_US);
    bit6Zero_next = demandRemote & (frameFormat == `FMT_DDS);
  end

  always @(posedge clk_sys) begin
    if (!rstn) begin
      remoteFrameAlarm <= 1'b0;
      ebitZero <= 1'b0;
      systemAis <= 1'b0;
      ts16RemoteMfAlarm <= 1'b0;
      ts16SystemAis <= 1'b0;
      ts16LineAis <= 1'b0;
      fsFrame12One <= 1'b0;
      slotBit2Zero <= 1'b0;
      slot24Bit6Zero <= 1'b0;
    end else begin
      remoteFrameAlarm <= remoteAlarm_next;
      ebitZero <= ebitZero_next;
      systemAis <= systemAis_next;
      ts16RemoteMfAlarm <= ts16Rma_next;
      ts16SystemAis <= ts16SysAis_next;
      ts16LineAis <= ts16LineAis_next;
      fsFrame12One <= fs12_next;
      slotBit2Zero <= bit2Zero_next;
      slot24Bit6Zero <= bit6Zero_next;
    end
  end

  // ----------------------------------------
  // data link override
  // ----------------------------------------
  // squelch wins over the yellow pattern: all ones is the safer line state
  reg [3:0] patternIndex_reg;
  wire squelchActive;
  wire yellowActive;
  wire [15:0] yellowPattern;

  assign yellowPattern = `ESF_YELLOW_PATTERN;
  assign squelchActive = dataLinkCtrl_reg[`DL_SQUELCH] &
    ((frameFormat == `FMT_ESF) | (frameFormat == `FMT_SLC96));
  assign yellowActive = demandRemote & (frameFormat == `FMT_ESF);

  always @(posedge clk_sys) begin
    if (!rstn) begin
      patternIndex_reg <= 4'hF;
      dataLinkOverride <= 1'b0;
      dataLinkBit <= 1'b1;
    end else begin
      dataLinkOverride <= squelchActive | yellowActive;
      if (squelchActive) begin
        dataLinkBit <= 1'b1;
        patternIndex_reg <= 4'hF;
      end else if (!yellowActive) begin
        dataLinkBit <= 1'b1;
        patternIndex_reg <= 4'hF;
      end else if (dataLinkBitStrobe) begin
        // pattern starts at its msb on the first strobe after it is asked for
        dataLinkBit <= yellowPattern[patternIndex_reg];
        patternIndex_reg <= patternIndex_reg - 4'h1;
      end
    end
  end

  // ----------------------------------------
  // loopback switching
  // ----------------------------------------
  // an off code beats an on code arriving in the same cycle
  wire lineOn;
  wire lineOff;
  wire payOn;
  wire payOff;

  assign lineOn = (aisLoopbackCtrl_reg[`AIS_LINE_LB] & lineLoopOnCode) |
    (aisLoopbackCtrl_reg[`AIS_ESF_LINE_LB] & esfLineLoopOnCode);
  assign lineOff = (aisLoopbackCtrl_reg[`AIS_LINE_LB] & lineLoopOffCode) |
    (aisLoopbackCtrl_reg[`AIS_ESF_LINE_LB] & esfLineLoopOffCode);
  assign payOn = aisLoopbackCtrl_reg[`AIS_ESF_PAY_LB] & esfPayloadLoopOnCode;
  assign payOff = aisLoopbackCtrl_reg[`AIS_ESF_PAY_LB] & esfPayloadLoopOffCode;

  always @(posedge clk_sys) begin
    if (!rstn) begin
      lineLoopback <= 1'b0;
      payloadLoopback <= 1'b0;
    end else begin
      if (lineOff) begin
        lineLoopback <= 1'b0;
      end else if (lineOn) begin
        lineLoopback <= 1'b1;
      end
      if (payOff) begin
        payloadLoopback <= 1'b0;
      end else if (payOn) begin
        payloadLoopback <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // wishbone read and acknowledge
  // ----------------------------------------
  always @* begin
    statusByte = {shortExpired | longExpired, payloadLoopback, lineLoopback,
      ts16SystemAis, ts16RemoteMfAlarm, systemAis, ebitZero, remoteFrameAlarm};
    case (wbAdrI)
      `ADDR_REMOTE_ALARM_CTRL: readData_next = remoteAlarmCtrl_reg;
      `ADDR_EBIT_CTRL: readData_next = ebitCtrl_reg;
      `ADDR_AIS_LOOPBACK_CTRL: readData_next = aisLoopbackCtrl_reg;
      `ADDR_MULTIFRAME_TIMER_CFG: readData_next = multiframeTimerCfg_reg;
      `ADDR_TS16_LINE_CTRL: readData_next = ts16LineCtrl_reg;
      `ADDR_SYSTEM_SIGNALING_CTRL: readData_next = systemSignalingCtrl_reg;
      `ADDR_DATA_LINK_CTRL: readData_next = dataLinkCtrl_reg;
      `ADDR_FORMAT_CTRL: readData_next = formatCtrl_reg;
      `ADDR_ACTION_STATUS: readData_next = statusByte;
      default: readData_next = 8'h00;
    endcase
  end

  // one wait state; unmapped addresses still answer, with zero
  always @(posedge clk_sys) begin
    if (!rstn) begin
      wbAckO <= 1'b0;
      wbDatO <= 32'h00000000;
    end else begin
      wbAckO <= busReq;
      if (busReq && !wbWeI) begin
        wbDatO <= {24'h000000, readData_next};
      end
    end
  end

endmodule

// [testbench/framer_alarm_checker.sv]
// checker: port-level assertions for the alarm action control block
// assumes one clock and that register writes land on the edge that raises ack
`timescale 1ns/1ps
`include "framer_alarm_defs.vh"
module framer_alarm_checker (
  input logic clk_sys,
  input logic rstn,
  input logic wbCycI,
  input logic wbStbI,
  input logic wbWeI,
  input logic [7:0] wbAdrI,
  input logic [3:0] wbSelI,
  input logic [31:0] wbDatI,
  input logic wbAckO,
  input logic frameAlignLost,
  input logic ts16MultiframeLost,
  input logic [3:0] rxSa6Code,
  input logic remoteFrameAlarm,
  input logic systemAis,
  input logic ts16RemoteMfAlarm,
  input logic dataLinkOverride,
  input logic dataLinkBit
);
  logic [7:0] sh [8];
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  // ----------------------------------------
  // register shadow, since only ports are visible
  // ----------------------------------------
  always @(posedge clk_sys) begin
    if (!rstn) begin
      sh <= '{default: 8'h00};
    end else if (wbCycI && wbStbI && wbWeI && !wbAckO && wbSelI[0] && wbAdrI[7:5] == 3'h0) begin
      sh[wbAdrI[4:2]] <= wbDatI[7:0];
    end
  end
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  AST_ACK_PULSE: assert property (wbAckO |=> !wbAckO)
    else $error("ack held longer than one cycle");
  AST_ACK_ANSWER: assert property (wbCycI && wbStbI && !wbAckO |=> wbAckO)
    else $error("request not acked on next edge");
  AST_QUIET: assert property (sh[0] == 8'h00 |=> !remoteFrameAlarm)
    else $error("remote alarm without enable");
  AST_RFA_LFA: assert property (sh[0][0] && frameAlignLost |=> remoteFrameAlarm)
    else $error("remote alarm missing on frame loss");
  AST_RFA_TS16: assert property (sh[0][1] && ts16MultiframeLost |=> remoteFrameAlarm)
    else $error("remote alarm missing on ts16 loss");
  AST_RFA_SA6_8: assert property (sh[0][4] && rxSa6Code == 4'h8 |=> remoteFrameAlarm)
    else $error("remote alarm missing on sa6 8");
  AST_RFA_SA6_C: assert property (sh[0][5] && rxSa6Code == 4'hC |=> remoteFrameAlarm)
    else $error("remote alarm missing on sa6 C");
  AST_SYS_AIS: assert property (sh[2][0] && frameAlignLost |=> systemAis)
    else $error("system ais missing on frame loss");
  AST_TS16_RMA: assert property (sh[4][4] && ts16MultiframeLost |=> ts16RemoteMfAlarm)
    else $error("ts16 remote alarm missing");
  AST_DL_SQUELCH: assert property (sh[6][4] && (sh[7][2:0] == `FMT_ESF ||
    sh[7][2:0] == `FMT_SLC96) |=> dataLinkOverride && dataLinkBit)
    else $error("data link not squelched");
  cover property (wbAckO && !wbWeI);
  cover property (remoteFrameAlarm && systemAis);
  cover property (dataLinkOverride && !dataLinkBit);
endmodule

bind framer_alarm_action_control framer_alarm_checker chk_u (
  .clk_sys(clk_sys), .rstn(rstn), .wbCycI(wbCycI), .wbStbI(wbStbI), .wbWeI(wbWeI),
  .wbAdrI(wbAdrI), .wbSelI(wbSelI), .wbDatI(wbDatI), .wbAckO(wbAckO),
  .frameAlignLost(frameAlignLost), .ts16MultiframeLost(ts16MultiframeLost),
  .rxSa6Code(rxSa6Code), .remoteFrameAlarm(remoteFrameAlarm), .systemAis(systemAis),
  .ts16RemoteMfAlarm(ts16RemoteMfAlarm), .dataLinkOverride(dataLinkOverride),
  .dataLinkBit(dataLinkBit)
);

// [testbench/line_side_model.sv]
// line-side model: strobes 16 data link slots and collects the bits sent
// assumes the block answers a strobe one edge later; run low restarts it
`timescale 1ns/1ps
module line_side_model (
  input logic clk_sys,
  input logic run,
  input logic dataLinkBit,
  output logic dataLinkBitStrobe,
  output logic [15:0] dlBits,
  output logic [4:0] nBits
);
  logic [1:0] phase;
  logic [4:0] nSent;
  logic strobeDly;
  always @(posedge clk_sys) begin
    if (!run) begin
      phase <= 2'h0;
      nSent <= 5'h00;
      nBits <= 5'h00;
      strobeDly <= 1'h0;
      dataLinkBitStrobe <= 1'h0;
    end else begin
      phase <= phase + 2'h1;
      dataLinkBitStrobe <= (phase == 2'h3) && (nSent < 5'h10);
      nSent <= nSent + {4'h0, (phase == 2'h3) && (nSent < 5'h10)};
      strobeDly <= dataLinkBitStrobe;
      if (strobeDly) begin
        dlBits <= {dlBits[14:0], dataLinkBit};
        nBits <= nBits + 5'h01;
      end
    end
  end
endmodule

// [testbench/test_framer_alarm_action_control.sv]
// self-checking bench for the alarm action control block
// assumes the designer's register map and one-edge output latency
`timescale 1ns/1ps
module test_framer_alarm_action_control;
  logic clk_sys, rstn, wbCycI, wbStbI, wbWeI, run;
  logic [7:0] wbAdrI, v;
  logic [3:0] wbSelI, rxSa6Code, cnd, s;
  logic [31:0] wbDatI, rd;
  logic [5:0] lbCode;
  wire wbAckO, dataLinkBit, dataLinkBitStrobe;
  wire [31:0] wbDatO;
  wire [11:0] alm;
  wire [15:0] dlBits;
  wire [4:0] nBits;
  int error_cnt, checked, cycles, seed;
  framer_alarm_action_control #(.MF_SHORT_CYCLES(20), .MF_LONG_CYCLES(50)) dut_u (
    .clk_sys(clk_sys), .rstn(rstn), .wbCycI(wbCycI), .wbStbI(wbStbI), .wbWeI(wbWeI),
    .wbAdrI(wbAdrI), .wbSelI(wbSelI), .wbDatI(wbDatI), .wbDatO(wbDatO), .wbAckO(wbAckO),
    .frameAlignLost(cnd[0]), .ts16MultiframeLost(cnd[1]), .ts0MultiframeLost(cnd[2]),
    .crc4Error(cnd[3]), .rxSa6Code(rxSa6Code), .lineLoopOnCode(lbCode[0]),
    .lineLoopOffCode(lbCode[1]), .esfLineLoopOnCode(lbCode[2]), .esfLineLoopOffCode(lbCode[3]),
    .esfPayloadLoopOnCode(lbCode[4]), .esfPayloadLoopOffCode(lbCode[5]),
    .dataLinkBitStrobe(dataLinkBitStrobe), .remoteFrameAlarm(alm[0]), .ebitZero(alm[1]),
    .systemAis(alm[2]), .ts16RemoteMfAlarm(alm[3]), .ts16SystemAis(alm[4]),
    .fsFrame12One(alm[5]), .slotBit2Zero(alm[6]), .slot24Bit6Zero(alm[7]),
    .dataLinkOverride(alm[8]), .dataLinkBit(dataLinkBit), .lineLoopback(alm[9]),
    .payloadLoopback(alm[10]), .ts16LineAis(alm[11]));
  line_side_model model_u (.clk_sys(clk_sys), .run(run), .dataLinkBit(dataLinkBit),
    .dataLinkBitStrobe(dataLinkBitStrobe), .dlBits(dlBits), .nBits(nBits));
  // ----------------------------------------
  // expectations and bus tasks
  // ----------------------------------------
  function automatic logic [31:0] exp_reg(input logic [7:0] a, input logic [7:0] d);
    return (a >= 8'h20) ? 32'h0 : (a == 8'h1C) ? {29'h0, d[2:0]} : {24'h0, d};
  endfunction
  function automatic logic sa6_hit(input logic [3:0] c);
    return c == 4'h8 || c == 4'hC;
  endfunction
  task chkb(input logic got, input logic exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %0t: flag %b expected %b", $time, got, exp);
    end
  endtask
  task chkw(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %0t: word %h expected %h", $time, got, exp);
    end
  endtask
  // hold the request until ack is seen at an edge; the timeout cuts a hang
  task wbx(input logic [7:0] a, input logic [7:0] d, input logic w);
    wbCycI <= 1'h1;
    wbStbI <= 1'h1;
    wbWeI <= w;
    wbAdrI <= a;
    wbDatI <= {24'h0, d};
    @(posedge clk_sys);
    while (wbAckO !== 1'h1) @(posedge clk_sys);
    rd = wbDatO;
    wbCycI <= 1'h0;
    wbStbI <= 1'h0;
    @(posedge clk_sys);
  endtask
  task auto_chk(input logic [7:0] a, input logic [7:0] d, input logic [3:0] c,
    input logic [3:0] q, input int o);
    wbx(a, d, 1'h1);
    cnd <= c;
    rxSa6Code <= q;
    repeat (2) @(posedge clk_sys);
    chkb(alm[o], 1'h1);
    cnd <= 4'h0;
    rxSa6Code <= 4'h0;
    repeat (2) @(posedge clk_sys);
    chkb(alm[o], 1'h0);
    wbx(a, 8'h00, 1'h1);
  endtask
  task tmr_chk(input logic [7:0] a, input logic [7:0] d, input logic [7:0] f, input int n,
    input int o);
    wbx(8'h0C, f, 1'h1);
    wbx(a, d, 1'h1);
    cnd[2] <= 1'h1;
    // count reaches n after n edges, the output follows one edge later
    repeat (n + 1) @(posedge clk_sys);
    chkb(alm[o], 1'h0);
    @(posedge clk_sys);
    chkb(alm[o], 1'h1);
    cnd[2] <= 1'h0;
    // counter clear and output register: two stages to drain
    repeat (3) @(posedge clk_sys);
    chkb(alm[o], 1'h0);
    wbx(a, 8'h00, 1'h1);
  endtask
  task pulse(input logic [5:0] c);
    lbCode <= c;
    @(posedge clk_sys);
    lbCode <= 6'h00;
    repeat (2) @(posedge clk_sys);
  endtask
  task lb_chk(input logic [7:0] d, input int k, input int o);
    wbx(8'h08, d, 1'h1);
    pulse(6'(1 << (2 * k)));
    chkb(alm[o], d != 8'h00);
    pulse(6'(2 << (2 * k)));
    chkb(alm[o], 1'h0);
    wbx(8'h08, 8'h00, 1'h1);
  endtask
  task dem_chk(input logic [2:0] f, input logic [7:0] a, input logic [7:0] d, input int o);
    wbx(8'h1C, {5'h00, f}, 1'h1);
    wbx(a, d, 1'h1);
    chkb(alm[o], 1'h1);
    wbx(a, 8'h00, 1'h1);
    chkb(alm[o], 1'h0);
  endtask
  task dl_chk(input logic [15:0] e);
    run <= 1'h1;
    @(posedge clk_sys);
    while (nBits !== 5'h10) @(posedge clk_sys);
    chkw({16'h0, dlBits}, {16'h0, e});
    run <= 1'h0;
    @(posedge clk_sys);
  endtask
  task finish_test;
    $display("comparisons %0d, mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // ----------------------------------------
  // clock, timeout and test sequence
  // ----------------------------------------
  initial begin
    clk_sys = 1'h0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      error_cnt++;
      finish_test();
    end
  end
  initial begin
    {wbCycI, wbStbI, wbWeI, run, wbAdrI, wbDatI, rxSa6Code, lbCode} = '0;
    {error_cnt, checked, cycles} = '0;
    wbSelI = 4'hF;
    cnd = 4'h1;
    seed = 32'h2BD0;
    rstn = 1'h0;
    repeat (4) @(posedge clk_sys);
    rstn <= 1'h1;
    @(posedge clk_sys);
    for (int i = 0; i < 10; i++) begin
      wbx(8'(i * 4), 8'h00, 1'h0);
      chkw(rd, 32'h0);
    end
    chkb(alm[0], 1'h0);
    cnd <= 4'h0;
    for (int i = 0; i < 10; i++) begin
      v = 8'($random(seed));
      wbx(8'(i * 4), v, 1'h1);
      wbx(8'(i * 4), 8'h00, 1'h0);
      chkw(rd, exp_reg(8'(i * 4), v));
      wbx(8'(i * 4), 8'h00, 1'h1);
    end
    $display("register test done");
    wbx(8'h1C, 8'h05, 1'h1);
    auto_chk(8'h00, 8'h01, 4'h1, 4'h0, 0);
    auto_chk(8'h00, 8'h02, 4'h2, 4'h0, 0);
    auto_chk(8'h00, 8'h04, 4'h4, 4'h0, 0);
    auto_chk(8'h00, 8'h10, 4'h0, 4'h8, 0);
    auto_chk(8'h00, 8'h20, 4'h0, 4'hC, 0);
    auto_chk(8'h04, 8'h08, 4'h8, 4'h0, 1);
    auto_chk(8'h04, 8'h10, 4'h4, 4'h0, 1);
    auto_chk(8'h08, 8'h01, 4'h1, 4'h0, 2);
    auto_chk(8'h10, 8'h10, 4'h2, 4'h0, 3);
    auto_chk(8'h14, 8'h40, 4'h2, 4'h0, 4);
    wbx(8'h00, 8'h30, 1'h1);
    for (int i = 0; i < 12; i++) begin
      s = (i == 0) ? 4'h8 : (i == 1) ? 4'hC : 4'($random(seed));
      rxSa6Code <= s;
      repeat (2) @(posedge clk_sys);
      chkb(alm[0], sa6_hit(s));
    end
    rxSa6Code <= 4'h0;
    wbx(8'h00, 8'h00, 1'h1);
    $display("automatic test done");
    tmr_chk(8'h00, 8'h08, 8'h05, 20, 0);
    tmr_chk(8'h04, 8'h20, 8'h09, 50, 1);
    tmr_chk(8'h08, 8'h02, 8'h05, 20, 2);
    wbx(8'h0C, 8'h85, 1'h1);
    wbx(8'h00, 8'h08, 1'h1);
    cnd[2] <= 1'h1;
    repeat (30) @(posedge clk_sys);
    chkb(alm[0], 1'h0);
    cnd[2] <= 1'h0;
    wbx(8'h00, 8'h00, 1'h1);
    wbx(8'h0C, 8'h00, 1'h1);
    lb_chk(8'h10, 0, 9);
    lb_chk(8'h40, 1, 9);
    lb_chk(8'h80, 2, 10);
    lb_chk(8'h00, 0, 9);
    $display("timer and loopback test done");
    dem_chk(3'h1, 8'h00, 8'h40, 5);
    dem_chk(3'h0, 8'h00, 8'h80, 6);
    dem_chk(3'h2, 8'h00, 8'h80, 7);
    dem_chk(3'h5, 8'h00, 8'h80, 0);
    dem_chk(3'h5, 8'h10, 8'h20, 3);
    dem_chk(3'h5, 8'h10, 8'h40, 11);
    dem_chk(3'h3, 8'h00, 8'h80, 8);
    wbx(8'h1C, 8'h03, 1'h1);
    wbx(8'h00, 8'h80, 1'h1);
    dl_chk(16'hFF00);
    wbx(8'h18, 8'h10, 1'h1);
    dl_chk(16'hFFFF);
    chkb(alm[8], 1'h1);
    wbx(8'h1C, 8'h04, 1'h1);
    dl_chk(16'hFFFF);
    // idle data link is all ones too, so the override flag is what tells squelch apart
    chkb(alm[8], 1'h1);
    $display("on-demand test done");
    wbx(8'h00, 8'h01, 1'h1);
    cnd <= 4'h1;
    repeat (2) @(posedge clk_sys);
    chkb(alm[0], 1'h1);
    rstn <= 1'h0;
    repeat (2) @(posedge clk_sys);
    rstn <= 1'h1;
    repeat (2) @(posedge clk_sys);
    chkb(alm[0], 1'h0);
    chkb(alm[8], 1'h0);
    wbx(8'h00, 8'h00, 1'h0);
    chkw(rd, 32'h0);
    cnd <= 4'h0;
    $display("reset test done");
    finish_test();
  end
endmodule
